/* hdl/timer_src_pkg.sv */
//
// Function
// - timer 1 primary bit: 0 picks osc/16, 1 defers to secondary bit 5
// - timer 1 secondary bit: 0 picks osc/4096, 1 picks external pin
// - timer 2 primary bit: 0 defers to bit 4, 1 picks external pin
// - timer 2 secondary bit: 0 picks osc/16, 1 picks timer 1 overflow
// - timer 5 secondary bit 6: 0 timer 2 overflow, 1 timer 4 overflow
// - timer 6 source bit: 0 osc/16, 1 timer 5 overflow
// - timers 1 and 2 halt while mode one bits 2 and 3 set
// - timers 3 to 6 halt while mode two bits 2,3,5,6 set
// - timer 3 source decoded from mode two bit 0 with the external t3AltSelect input
// - timer 4 field 00 t3 ovf, 01 osc/16, 10 osc/2, 11 sub osc
// - timer 5 primary bit 7: 0 osc/16, 1 defers to secondary bit
// - event flags set by hardware; software writes 0 to clear, 1 keeps
package timer_src_pkg;
    localparam logic [7:0] ADDR_MODE_ONE = 8'hF4;
    localparam logic [7:0] ADDR_MODE_TWO = 8'hF5;
    localparam logic [7:0] ADDR_FLAGS = 8'hF6;
    localparam logic [7:0] ADDR_MASK = 8'hF7;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int NUM_TIMERS = 6;
    localparam int PRESCALE_BITS = 12;
    // prescaler taps: divide by 2, 16, 4096
    localparam int TAP_DIV2 = 0;
    localparam int TAP_DIV16 = 3;
    localparam int TAP_DIV4096 = 11;

    typedef struct packed {
        logic t6SrcInternal;
        logic t5SrcSecondary;
        logic t1SrcSecondary;
        logic t2SrcSecondary;
        logic t2Halt;
        logic t1Halt;
        logic t2SrcPrimary;
        logic t1SrcPrimary;
    } mode_one_t;

    typedef struct packed {
        logic t5SrcPrimary;
        logic t6Halt;
        logic t5Halt;
        logic t4SrcHigh;
        logic t4Halt;
        logic t3Halt;
        logic t4SrcLow;
        logic t3SrcSelect;
    } mode_two_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : timer_src_pkg

/* hdl/timer_source_select_and_stop.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module timer_source_select_and_stop
    import timer_src_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    input wire logic extCountPin,
    input wire logic subOscTick,
    input wire logic highSpeed,
    input wire logic t3AltSelect,
    output logic [7:0] count [NUM_TIMERS],
    output logic [NUM_TIMERS-1:0] overflow,
    output logic irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] pinSync;
    logic [1:0] subSync;
    logic pinLast;
    logic subLast;
    logic pinEdge;
    logic subEdge;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pinSync <= 2'h0;
            subSync <= 2'h0;
            pinLast <= 1'b0;
            subLast <= 1'b0;
        end
        else
        begin
            pinSync <= {pinSync[0], extCountPin};
            subSync <= {subSync[0], subOscTick};
            pinLast <= pinSync[1];
            subLast <= subSync[1];
        end
    end

    assign pinEdge = pinSync[1] & ~pinLast;
    assign subEdge = subSync[1] & ~subLast;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    mode_one_t modeOne;
    mode_two_t modeTwo;
    logic [7:0] flags;
    logic [7:0] mask;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            modeOne <= mode_one_t'(MODE_RESET);
            modeTwo <= mode_two_t'(MODE_RESET);
            mask <= 8'h00;
        end
        else if (req.wr)
        begin
            if (req.addr == ADDR_MODE_ONE)
                modeOne <= mode_one_t'(req.wdata);
            if (req.addr == ADDR_MODE_TWO)
                modeTwo <= mode_two_t'(req.wdata);
            if (req.addr == ADDR_MASK)
                mask <= {2'h0, req.wdata[5:0]};
        end
    end

    // set wins over clear, both from a write of 0 and from a read
    logic [7:0] next_flags;
    always_comb
    begin
        next_flags = flags;
        if (req.wr && req.addr == ADDR_FLAGS)
            next_flags = flags & req.wdata;
        if (req.rd && req.addr == ADDR_FLAGS)
            next_flags = 8'h00;
        next_flags = next_flags | {2'h0, overflow};
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            flags <= 8'h00;
        else
            flags <= next_flags;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                ADDR_MODE_ONE: rdata <= modeOne;
                ADDR_MODE_TWO: rdata <= modeTwo;
                ADDR_FLAGS: rdata <= flags;
                ADDR_MASK: rdata <= mask;
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    assign irq = |(flags & mask);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // in low speed the chain advances only on sub oscillator edges
    logic [PRESCALE_BITS-1:0] prescale;
    logic preStep;
    logic [PRESCALE_BITS-1:0] carryTick;

    assign preStep = highSpeed ? 1'b1 : subEdge;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            prescale <= '0;
        else if (preStep)
            prescale <= prescale + 1'b1;
    end

    // tick for divide by 2^(i+1): all lower bits and bit i set on a step
    genvar gi;
    generate
        for (gi = 0; gi < PRESCALE_BITS; gi++)
        begin : g_tick
            assign carryTick[gi] = preStep & (&prescale[gi:0]);
        end
    endgenerate

    logic div2;
    logic div16;
    logic div4096;
    assign div2 = carryTick[TAP_DIV2];
    assign div16 = carryTick[TAP_DIV16];
    assign div4096 = carryTick[TAP_DIV4096];

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] halt;
    logic t1Second;
    logic t2Second;
    logic t5Second;

    assign t1Second = modeOne.t1SrcSecondary ? pinEdge : div4096;
    assign t2Second = modeOne.t2SrcSecondary ? overflow[0] : div16;
    assign t5Second = modeOne.t5SrcSecondary ? overflow[3] : overflow[1];

    always_comb
    begin
        tick[0] = modeOne.t1SrcPrimary ? t1Second : div16;
        tick[1] = modeOne.t2SrcPrimary ? pinEdge : t2Second;
        // timer 3: with the companion bit set, bit 0 picks the pin or timer 2 overflow, else bit 0 picks osc/16 or /4096
        case ({t3AltSelect, modeTwo.t3SrcSelect})
            2'b00: tick[2] = div16;
            2'b01: tick[2] = div4096;
            2'b10: tick[2] = pinEdge;
            2'b11: tick[2] = overflow[1];
            default: tick[2] = 1'b0;
        endcase
        case ({modeTwo.t4SrcHigh, modeTwo.t4SrcLow})
            2'b00: tick[3] = overflow[2];
            2'b01: tick[3] = div16;
            2'b10: tick[3] = div2;
            2'b11: tick[3] = subEdge;
            default: tick[3] = 1'b0;
        endcase
        tick[4] = modeTwo.t5SrcPrimary ? t5Second : div16;
        tick[5] = modeOne.t6SrcInternal ? overflow[4] : div16;
    end

    assign halt = {modeTwo.t6Halt, modeTwo.t5Halt, modeTwo.t4Halt, modeTwo.t3Halt,
                   modeOne.t2Halt, modeOne.t1Halt};

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // overflow is a registered pulse, so a cascade lags its source by a cycle
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++)
        begin : g_timer
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                begin
                    count[gi] <= 8'h00;
                    overflow[gi] <= 1'b0;
                end
                else
                begin
                    overflow[gi] <= 1'b0;
                    if (tick[gi] && !halt[gi])
                    begin
                        count[gi] <= count[gi] + 8'h01;
                        overflow[gi] <= (count[gi] == 8'hFF);
                    end
                end
            end

            property p_halt_hold;
                @(posedge sys_clk) disable iff (srst)
                    halt[gi] && $past(halt[gi]) |-> $stable(count[gi]);
            endproperty
            a_halt_hold: assert property (p_halt_hold)
                else $error("halted timer changed count");

            property p_ovf_wrap;
                @(posedge sys_clk) disable iff (srst)
                    overflow[gi] |-> count[gi] == 8'h00 && $past(count[gi]) == 8'hFF;
            endproperty
            a_ovf_wrap: assert property (p_ovf_wrap)
                else $error("overflow without wrap");

            property p_flag_set;
                @(posedge sys_clk) disable iff (srst)
                    overflow[gi] |=> flags[gi];
            endproperty
            a_flag_set: assert property (p_flag_set)
                else $error("overflow did not set flag");
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_t1_div16;
        @(posedge sys_clk) disable iff (srst)
            !modeOne.t1SrcPrimary && !modeOne.t1Halt && div16 |=> count[0] != $past(count[0]);
    endproperty
    a_t1_div16: assert property (p_t1_div16)
        else $error("timer 1 missed osc/16 tick");

    property p_t1_pin;
        @(posedge sys_clk) disable iff (srst)
            modeOne.t1SrcPrimary && modeOne.t1SrcSecondary && !modeOne.t1Halt && !pinEdge
            |=> count[0] == $past(count[0]);
    endproperty
    a_t1_pin: assert property (p_t1_pin)
        else $error("timer 1 counted without pin edge");

    property p_t2_pin;
        @(posedge sys_clk) disable iff (srst)
            modeOne.t2SrcPrimary && !modeOne.t2Halt && pinEdge |=> count[1] != $past(count[1]);
    endproperty
    a_t2_pin: assert property (p_t2_pin)
        else $error("timer 2 missed pin edge");

    property p_t2_cascade;
        @(posedge sys_clk) disable iff (srst)
            !modeOne.t2SrcPrimary && modeOne.t2SrcSecondary && !modeOne.t2Halt && overflow[0]
            |=> count[1] != $past(count[1]);
    endproperty
    a_t2_cascade: assert property (p_t2_cascade)
        else $error("timer 2 missed timer 1 overflow");

    // both branches of the timer 5 secondary select are spelled out on their own
    property p_t5_cascade;
        @(posedge sys_clk) disable iff (srst)
            modeTwo.t5SrcPrimary && !modeTwo.t5Halt
            && ((modeOne.t5SrcSecondary && overflow[3]) || (!modeOne.t5SrcSecondary && overflow[1]))
            |=> count[4] != $past(count[4]);
    endproperty
    a_t5_cascade: assert property (p_t5_cascade)
        else $error("timer 5 missed selected overflow");

    property p_t3_pin;
        @(posedge sys_clk) disable iff (srst)
            t3AltSelect && !modeTwo.t3SrcSelect && !modeTwo.t3Halt && pinEdge
            |=> count[2] != $past(count[2]);
    endproperty
    a_t3_pin: assert property (p_t3_pin)
        else $error("timer 3 missed pin edge");

    property p_t6_cascade;
        @(posedge sys_clk) disable iff (srst)
            modeOne.t6SrcInternal && !modeTwo.t6Halt && overflow[4] |=> count[5] != $past(count[5]);
    endproperty
    a_t6_cascade: assert property (p_t6_cascade)
        else $error("timer 6 missed timer 5 overflow");

    property p_t4_sub;
        @(posedge sys_clk) disable iff (srst)
            modeTwo.t4SrcHigh && modeTwo.t4SrcLow && !modeTwo.t4Halt && subEdge
            |=> count[3] != $past(count[3]);
    endproperty
    a_t4_sub: assert property (p_t4_sub)
        else $error("timer 4 missed sub osc edge");

    property p_flag_keep;
        @(posedge sys_clk) disable iff (srst)
            req.wr && req.addr == ADDR_FLAGS && !req.rd
            |=> (flags & ~$past(flags | {2'h0, overflow})) == 8'h00;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("written one set a flag");
endmodule : timer_source_select_and_stop

/* test/timer_source_select_and_stop_test.sv */
`timescale 1ns/1ps
module timer_source_select_and_stop_test;
    import timer_src_pkg::*;

    typedef struct {
        logic [7:0] m1;
        logic [7:0] m2;
        logic hs;
        int idx;
        int n;
        int lo;
        int hi;
    } row_t;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic extCountPin = 1'b0;
    logic subOscTick = 1'b0;
    logic highSpeed = 1'b1;
    logic t3AltSelect = 1'b0;
    logic [7:0] count [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] overflow;
    logic irq;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] rv;
    logic [7:0] c0;
    logic [7:0] c1;
    row_t rows [12];

    timer_source_select_and_stop u_dut (
        .sys_clk(sys_clk),
        .srst(srst),
        .req(req),
        .rdata(rdata),
        .extCountPin(extCountPin),
        .subOscTick(subOscTick),
        .highSpeed(highSpeed),
        .t3AltSelect(t3AltSelect),
        .count(count),
        .overflow(overflow),
        .irq(irq)
    );

    initial forever #10 sys_clk = ~sys_clk;

    // ----------------------------------------
    // bus and check helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // pin edges are stretched so the two-flop synchroniser cannot miss them
    task automatic pulse(input bit sub, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            {subOscTick, extCountPin} <= sub ? 2'b10 : 2'b01;
            repeat (3) @(posedge sys_clk);
            {subOscTick, extCountPin} <= 2'b00;
            repeat (2) @(posedge sys_clk);
        end
    endtask : pulse

    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask : settle

    // counting start is fuzzy by one tick, hence the window
    task automatic rate(input int idx, input int n, input int lo, input int hi);
        logic [7:0] d;
        #1 c0 = count[idx];
        repeat (n) @(posedge sys_clk);
        #1 d = count[idx] - c0;
        chk("rate", (d >= lo && d <= hi) ? 8'h01 : 8'h00, 8'h01);
    endtask : rate

    task automatic wait_count(input int idx, input logic [7:0] exp);
        for (int k = 0; k < 40 && count[idx] !== exp; k++) @(posedge sys_clk);
        #1 chk("count", count[idx], exp);
    endtask : wait_count

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rows = '{
            '{8'h08, 8'h00, 1'b1, 0, 160, 9, 11},
            '{8'h09, 8'h00, 1'b1, 0, 8192, 1, 3},
            '{8'h04, 8'h00, 1'b1, 1, 160, 9, 11},
            '{8'h08, 8'h00, 1'b1, 5, 160, 9, 11},
            '{8'h08, 8'h00, 1'b1, 4, 160, 9, 11},
            '{8'h08, 8'h00, 1'b1, 2, 160, 9, 11},
            '{8'h08, 8'h01, 1'b1, 2, 8192, 1, 3},
            '{8'h08, 8'h02, 1'b1, 3, 160, 9, 11},
            '{8'h08, 8'h10, 1'b1, 3, 40, 19, 21},
            '{8'h0C, 8'h6C, 1'b1, 0, 160, 0, 0},
            '{8'h0C, 8'h6C, 1'b1, 2, 160, 0, 0},
            '{8'h08, 8'h00, 1'b0, 0, 160, 0, 0}
        };
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        for (int i = 0; i < NUM_TIMERS; i++) chk("countReset", count[i], 8'h00);
        rd(ADDR_MODE_ONE, rv);
        chk("modeOneReset", rv, MODE_RESET);
        rd(ADDR_MODE_TWO, rv);
        chk("modeTwoReset", rv, MODE_RESET);
        $display("reset test done");
        foreach (rows[i])
        begin
            @(posedge sys_clk);
            highSpeed <= rows[i].hs;
            wr(ADDR_MODE_ONE, rows[i].m1);
            wr(ADDR_MODE_TWO, rows[i].m2);
            rd(ADDR_MODE_ONE, rv);
            chk("modeOne", rv, rows[i].m1);
            rd(ADDR_MODE_TWO, rv);
            chk("modeTwo", rv, rows[i].m2);
            rate(rows[i].idx, rows[i].n, rows[i].lo, rows[i].hi); // to
            $display("row %0d done", i);
        end
        // ----------------------------------------
        // hand-written cases
        // ----------------------------------------
        wr(8'hF0, 8'hFF);
        rd(8'hF0, rv);
        chk("unmapped", rv, 8'h00);
        wr(ADDR_MASK, 8'hFF);
        rd(ADDR_MASK, rv);
        chk("mask", rv, 8'h3F);
        wr(ADDR_MODE_TWO, 8'h76);
        settle();
        c0 = count[3];
        c1 = count[0];
        pulse(1'b1, 16);
        wait_count(3, c0 + 8'h10);
        wait_count(0, c1 + 8'h01);
        $display("sub oscillator test done");
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_MODE_ONE, 8'h31);
        rd(ADDR_FLAGS, rv);
        settle();
        c0 = count[1];
        pulse(1'b0, 256);
        wait_count(1, c0 + 8'h01);
        chk("irqSet", {7'd0, irq}, 8'h01);
        wr(ADDR_FLAGS, 8'hFF);
        settle();
        chk("irqKeep", {7'd0, irq}, 8'h01);
        wr(ADDR_MASK, 8'h00);
        settle();
        chk("irqMasked", {7'd0, irq}, 8'h00);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_FLAGS, 8'h3E);
        settle();
        chk("irqCleared", {7'd0, irq}, 8'h00);
        pulse(1'b0, 256);
        for (int k = 0; k < 40 && irq !== 1'b1; k++) @(posedge sys_clk);
        chk("irqSetAgain", {7'd0, irq}, 8'h01);
        rd(ADDR_FLAGS, rv);
        chk("flagRead", rv & 8'h01, 8'h01);
        settle();
        chk("irqReadClear", {7'd0, irq}, 8'h00);
        $display("cascade and interrupt test done");
        // timer 5 follows timer 4 overflow, then timer 2 overflow while timer 2 is halted
        @(posedge sys_clk);
        highSpeed <= 1'b1;
        wr(ADDR_MODE_ONE, 8'h4C);
        wr(ADDR_MODE_TWO, 8'hD4);
        rate(4, 1100, 2, 3);
        wr(ADDR_MODE_ONE, 8'h0C);
        rate(4, 600, 0, 0);
        wr(ADDR_MODE_TWO, 8'h68);
        @(posedge sys_clk);
        t3AltSelect <= 1'b1;
        settle();
        c0 = count[2];
        pulse(1'b0, 3);
        wait_count(2, c0 + 8'h03);
        @(posedge sys_clk);
        t3AltSelect <= 1'b0;
        $display("timer 5 and timer 3 source test done");
        wr(ADDR_MODE_ONE, 8'hA5);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        rd(ADDR_MODE_ONE, rv);
        chk("midReset", rv, MODE_RESET);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : timer_source_select_and_stop_test
